// ### logic/hpr_consts.svh
// constants of the host port and remote setup block
// assumes inclusion by the package and the host port module only
`ifndef HPR_CONSTS_SVH
`define HPR_CONSTS_SVH

`define HPR_MODE_OFF0       3'h0
`define HPR_MODE_ROM        3'h1
`define HPR_MODE_MUX        3'h2
`define HPR_MODE_SEP        3'h3
`define HPR_MODE_STB        3'h4
`define HPR_MODE_SER        3'h5

`define HPR_RDY_LOW_CYC     2

`define HPR_REG_CHEN_LO     5'h00
`define HPR_REG_CHEN_HI     5'h01
`define HPR_REG_RATE        5'h02
`define HPR_REG_TIMING      5'h03
`define HPR_REG_STATUS      5'h1F

// rate register fields
`define HPR_RATE_DR_LSB     0
`define HPR_RATE_POL_LSB    3
`define HPR_RATE_CM_LSB     6
// timing register fields
`define HPR_TIM_MAINTENANCE_RATE_SELECT_LSB    0
`define HPR_TIM_TRSEL_BIT   3
`define HPR_TIM_RESEL_BIT   4
`define HPR_TIM_CKM_BIT     5
`define HPR_TIM_CKC_BIT     6

// setup word layout
`define HPR_SU_CHEN_LSB     0
`define HPR_SU_DR_LSB       16
`define HPR_SU_POL_LSB      19
`define HPR_SU_CM_LSB       22
`define HPR_SU_TRSEL_BIT    24
`define HPR_SU_RESEL_BIT    25
`define HPR_SU_CKM_BIT      26
`define HPR_SU_CKC_BIT      27
`define HPR_SU_MAINTENANCE_RATE_SELECT_LSB     28
`define HPR_SU_TIMING_MASK  31'h0F00_0000

`define HPR_SER_ADDR_LAST   4'h5
`define HPR_SER_DATA_LAST   4'hD
`define HPR_SER_CNT_MAX     4'hE

`define HPR_REG_RST         8'h00

// synchroniser lanes of active-low pins (select, write, read, controller select)
`define HPR_PIN_IDLE_INV    22'h07_0002

`endif

// ### logic/hpr_host_port.sv
// host port (multiplexed, strobe/acknowledge, serial) and remote setup
// assumes bus pins asynchronous, peer setup from link logic on clk
`timescale 1ns/10ps
`include "hpr_consts.svh"
module hpr_host_port
    import hpr_pkg::*;
#(
    parameter int RDY_LOW_CYC = `HPR_RDY_LOW_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [2:0]  host_port_mode_select,
    input  wire logic        chip_select_n,
    input  wire logic        write_strobe_or_direction,
    input  wire logic        read_strobe_n,
    input  wire logic        latch_strobe,
    input  wire logic [4:0]  index_in,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic      [7:0]  data_oe,
    output logic             ready_out,
    output logic             ready_oe,
    input  wire logic        remote_master_select_n,
    input  wire logic        local_timing_setting_select,
    input  wire logic [30:0] local_pin_setup,
    input  wire logic [30:0] peer_setup,
    input  wire logic        peer_setup_valid,
    input  wire logic        peer_is_master,
    output logic      [30:0] setup_to_peer,
    output logic             setup_to_peer_valid,
    output logic      [30:0] effective_setup,
    output logic             data_path_enable,
    output logic             remote_controlled
);
    if (RDY_LOW_CYC < 1 || RDY_LOW_CYC > 15) begin : g_bad_rdy
        $error("hpr_host_port: RDY_LOW_CYC out of 1..15");
    end

    logic [21:0] sync_lvl;
    logic        cs_n, wr, rd_n, ale, rms_n, lts;
    logic [4:0]  idx;
    logic [7:0]  din;
    logic [2:0]  mode_pins;

    // active-low pins pass inverted, so the synchroniser reset reads them idle
    hpr_pin_sync #(.WIDTH(22)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    ({host_port_mode_select, chip_select_n, write_strobe_or_direction, read_strobe_n,
                  latch_strobe, index_in, data_in, remote_master_select_n, local_timing_setting_select}
                 ^ `HPR_PIN_IDLE_INV),
        .level  (sync_lvl)
    );
    assign {mode_pins, cs_n, wr, rd_n, ale, idx, din, rms_n, lts} = sync_lvl ^ `HPR_PIN_IDLE_INV;

    // previous levels for edge detection
    logic cs_n_q, wr_q, rd_n_q, ale_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_n_q <= 1'b1;
            wr_q   <= 1'b1;
            rd_n_q <= 1'b1;
            ale_q  <= 1'b0;
        end else begin
            cs_n_q <= cs_n;
            wr_q   <= wr;
            rd_n_q <= rd_n;
            ale_q  <= ale;
        end
    end

    wire cs_fall  = cs_n_q & ~cs_n;
    wire cs_rise  = ~cs_n_q & cs_n;
    wire cs_act   = ~cs_n;
    wire wr_fall  = wr_q & ~wr;
    wire wr_rise  = ~wr_q & wr;
    wire rd_fall  = rd_n_q & ~rd_n;
    wire ale_fall = ale_q & ~ale;
    wire sck_rise = ~ale_q & ale;

    hpr_mode_e mode;
    assign mode = (mode_pins == `HPR_MODE_MUX) ? HPR_MUX :
                  (mode_pins == `HPR_MODE_STB) ? HPR_STB :
                  (mode_pins == `HPR_MODE_SER) ? HPR_SER : HPR_OFF;

    // configuration store
    logic [7:0]  regs [0:31];
    logic [4:0]  idx_r;
    logic        dir_rd_r;
    logic [3:0]  rdy_cnt_r;
    logic [3:0]  ser_cnt_r;
    logic [4:0]  ser_sh_r;
    logic [7:0]  ser_out_r;
    logic        ser_loaded_r;

    // serial framing: read flag, 5 index bits, 8 data bits, msb first
    wire        ser_mode   = (mode == HPR_SER) & cs_act;
    wire        ser_addr   = ser_mode & sck_rise & (ser_cnt_r == `HPR_SER_ADDR_LAST);
    wire [4:0]  ser_idx    = {ser_sh_r[3:0], idx[0]};
    wire        ser_is_rd  = ser_addr ? ser_sh_r[4] : dir_rd_r;
    wire        ser_edge1  = idx[1];
    wire        ser_drive  = ser_edge1 ? (ale_q & ~ale) : sck_rise;
    wire        ser_load   = ser_mode & ser_is_rd & ser_drive & ~ser_loaded_r &
                             (ser_addr | (ser_cnt_r > `HPR_SER_ADDR_LAST));
    wire        ser_shift  = ser_mode & ser_is_rd & ser_drive & ser_loaded_r;

    wire [4:0]  rd_idx     = ser_addr ? ser_idx : idx_r;
    wire [7:0]  status     = {5'h00, remote_controlled, data_path_enable, ~rms_n};
    wire [7:0]  rd_val     = (rd_idx == `HPR_REG_STATUS) ? status : regs[rd_idx];

    // single write port per mode
    wire        wr_mux = (mode == HPR_MUX) & cs_act & wr_rise;
    wire        wr_stb = (mode == HPR_STB) & cs_rise & ~dir_rd_r;
    wire        wr_ser = ser_mode & sck_rise & ~dir_rd_r & (ser_cnt_r == `HPR_SER_DATA_LAST);
    wire        wr_en  = wr_mux | wr_stb | wr_ser;
    wire [7:0]  wr_dat = wr_ser ? {ser_out_r[6:0], idx[0]} : din;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 32; i++) regs[i] <= `HPR_REG_RST;
        end else if (wr_en && idx_r != `HPR_REG_STATUS) begin
            regs[idx_r] <= wr_dat;
        end
    end

    // index and direction capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idx_r    <= 5'h00;
            dir_rd_r <= 1'b0;
        end else if (mode == HPR_MUX && ale_fall) begin
            idx_r    <= din[4:0];
        end else if (mode == HPR_STB && cs_fall) begin
            idx_r    <= idx;
            dir_rd_r <= wr;
        end else if (ser_addr) begin
            idx_r    <= ser_idx;
            dir_rd_r <= ser_sh_r[4];
        end
    end

    // serial bit counter and shifters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ser_cnt_r    <= 4'h0;
            ser_sh_r     <= 5'h00;
            ser_out_r    <= 8'h00;
            ser_loaded_r <= 1'b0;
        end else if (!ser_mode) begin
            ser_cnt_r    <= 4'h0;
            ser_loaded_r <= 1'b0;
        end else begin
            if (sck_rise && ser_cnt_r != `HPR_SER_CNT_MAX) begin
                ser_cnt_r <= ser_cnt_r + 4'h1;
            end
            if (sck_rise && ser_cnt_r < `HPR_SER_ADDR_LAST) begin
                ser_sh_r  <= {ser_sh_r[3:0], idx[0]};
            end
            if (ser_load) begin
                ser_out_r    <= rd_val;
                ser_loaded_r <= 1'b1;
            end else if (ser_shift) begin
                ser_out_r    <= {ser_out_r[6:0], 1'b0};
            end else if (sck_rise && !dir_rd_r && ser_cnt_r > `HPR_SER_ADDR_LAST) begin
                ser_out_r    <= {ser_out_r[6:0], idx[0]};
            end
        end
    end

    // ready / acknowledge timing
    wire rdy_expire = (rdy_cnt_r == 4'h1);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_out <= 1'b1;
            ready_oe  <= 1'b0;
            rdy_cnt_r <= 4'h0;
        end else if ((mode != HPR_MUX && mode != HPR_STB) || !cs_act) begin
            ready_out <= 1'b1;
            ready_oe  <= 1'b0;
            rdy_cnt_r <= 4'h0;
        end else begin
            ready_oe <= 1'b1;
            if ((mode == HPR_MUX && (rd_fall || wr_fall)) || (mode == HPR_STB && cs_fall)) begin
                ready_out <= (mode == HPR_STB);
                rdy_cnt_r <= 4'(RDY_LOW_CYC);
            end else if (rdy_expire) begin
                ready_out <= (mode == HPR_MUX);
                rdy_cnt_r <= 4'h0;
            end else if (rdy_cnt_r != 4'h0) begin
                rdy_cnt_r <= rdy_cnt_r - 4'h1;
            end
        end
    end

    // data bus drive
    wire mux_rd_drv = (mode == HPR_MUX) & cs_act & ~rd_n;
    wire stb_rd_drv = (mode == HPR_STB) & cs_act & dir_rd_r & ~cs_fall;
    wire ser_drv    = ser_mode & (ser_load | ser_loaded_r);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= 8'h00;
            data_oe  <= 8'h00;
        end else if (ser_drv) begin
            data_out <= {7'h00, ser_load ? rd_val[7] : (ser_shift ? ser_out_r[6] : ser_out_r[7])};
            data_oe  <= 8'h01;
        end else if (mux_rd_drv || stb_rd_drv) begin
            data_out <= rd_val;
            data_oe  <= 8'hFF;
        end else begin
            data_out <= 8'h00;
            data_oe  <= 8'h00;
        end
    end

    // local setup from registers, or from pins with the port off
    hpr_setup_t reg_setup;
    hpr_setup_t local_setup;
    hpr_setup_t remote_mix;
    wire [7:0] r_rate = regs[`HPR_REG_RATE];
    wire [7:0] r_tim  = regs[`HPR_REG_TIMING];
    assign reg_setup = {r_tim[`HPR_TIM_MAINTENANCE_RATE_SELECT_LSB +: 3], r_tim[`HPR_TIM_CKC_BIT], r_tim[`HPR_TIM_CKM_BIT],
                        r_tim[`HPR_TIM_RESEL_BIT], r_tim[`HPR_TIM_TRSEL_BIT], r_rate[`HPR_RATE_CM_LSB +: 2],
                        r_rate[`HPR_RATE_POL_LSB +: 3], r_rate[`HPR_RATE_DR_LSB +: 3],
                        regs[`HPR_REG_CHEN_HI], regs[`HPR_REG_CHEN_LO]};
    assign local_setup = (mode == HPR_OFF) ? local_pin_setup : reg_setup;
    assign remote_mix  = lts ? ((peer_setup & ~`HPR_SU_TIMING_MASK) | (local_setup & `HPR_SU_TIMING_MASK))
                             : peer_setup;

    wire is_master  = ~rms_n;
    wire both_mstr  = is_master & peer_is_master;
    wire take_peer  = ~is_master & peer_is_master & peer_setup_valid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            setup_to_peer       <= 31'h0000_0000;
            setup_to_peer_valid <= 1'b0;
            effective_setup     <= 31'h0000_0000;
            data_path_enable    <= 1'b0;
            remote_controlled   <= 1'b0;
        end else begin
            setup_to_peer       <= local_setup;
            setup_to_peer_valid <= is_master;
            effective_setup     <= take_peer ? remote_mix : local_setup;
            data_path_enable    <= ~both_mstr;
            remote_controlled   <= take_peer;
        end
    end
endmodule // hpr_host_port

// ### logic/hpr_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins against clk
`timescale 1ns/10ps
module hpr_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] agree;

    if (WIDTH < 1) begin : g_bad_width
        $error("hpr_pin_sync: WIDTH must be positive");
    end

    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            level <= '0;
        end else begin
            s1_r  <= pin;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            level <= (agree & s3_r) | (~agree & level);
        end
    end
endmodule // hpr_pin_sync

// ### logic/hpr_pkg.sv
// types of the host port and remote setup block
// assumes the constants header sits beside it
`include "hpr_consts.svh"
package hpr_pkg;
    typedef enum logic [2:0] {
        HPR_OFF,
        HPR_MUX,
        HPR_STB,
        HPR_SER
    } hpr_mode_e;

    typedef logic [30:0] hpr_setup_t;
endpackage

// ### tb/hpr_host_model.sv
// host processor model driving the bus pins in all three port modes
// assumes mode pins set by the bench; shared bus resolved here
`timescale 1ns/10ps
module hpr_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe,
    input  wire logic       ready_out,
    input  wire logic       ready_oe,
    output logic            chip_select_n,
    output logic            write_strobe_or_direction,
    output logic            read_strobe_n,
    output logic            latch_strobe,
    output logic [4:0]      index_in,
    output logic [7:0]      data_in
);
    logic       hen;
    logic [7:0] hval;
    logic [7:0] last_r;
    initial begin
        {chip_select_n, write_strobe_or_direction, read_strobe_n} = 3'h7;
        {latch_strobe, hen, hval, last_r, index_in} = '0;
    end
    // nobody driving: bus shows inverse of its last level
    assign data_in = (data_oe & data_out) | (~data_oe & (hen ? hval : ~last_r));
    always @(posedge clk) last_r <= data_in;
    task tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task mux_acc(input logic r, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int i;
        chip_select_n <= 1'b0;
        hen <= 1'b1;
        hval <= {3'h0, a};
        tk(6);
        latch_strobe <= 1'b1;
        tk(6);
        latch_strobe <= 1'b0;
        tk(6);
        hen <= !r;
        hval <= d;
        if (r) read_strobe_n <= 1'b0;
        else write_strobe_or_direction <= 1'b0;
        for (i = 0; i < 30 && !(ready_oe && !ready_out); i++) tk(1);
        for (i = 0; i < 30 && !ready_out; i++) tk(1);
        q = data_out;
        read_strobe_n <= 1'b1;
        write_strobe_or_direction <= 1'b1;
        tk(8);
        hen <= 1'b0;
        chip_select_n <= 1'b1;
        tk(8);
    endtask
    task stb_acc(input logic r, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int i;
        write_strobe_or_direction <= r;
        index_in <= a;
        hen <= !r;
        hval <= d;
        tk(2);
        chip_select_n <= 1'b0;
        for (i = 0; i < 30 && !(ready_oe && !ready_out); i++) tk(1);
        tk(1);
        q = data_out;
        tk(2);
        chip_select_n <= 1'b1;
        tk(8);
        hen <= 1'b0;
        write_strobe_or_direction <= 1'b1;
        tk(1);
    endtask
    task ser_acc(input logic r, input logic [4:0] a, input logic [7:0] d, input logic e, output logic [7:0] q);
        logic [13:0] f;
        int          i;
        f = {r, a, d};
        index_in <= {3'h0, e, 1'b0};
        chip_select_n <= 1'b0;
        tk(6);
        for (i = 0; i < 14; i++) begin
            index_in[0] <= f[13-i];
            tk(6);
            latch_strobe <= 1'b1;
            tk(6);
            latch_strobe <= 1'b0;
            tk(8);
            if (i > 4 && i < 13) q = {q[6:0], data_out[0]};
        end
        tk(6);
        chip_select_n <= 1'b1;
        tk(8);
    endtask
endmodule // hpr_host_model

// ### tb/hpr_port_monitor.sv
// checker of host port pin timing and remote setup outputs
// assumes binding onto hpr_host_port, one clock domain
`timescale 1ns/10ps
module hpr_port_chk
    import hpr_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [2:0]  host_port_mode_select,
    input wire logic        chip_select_n,
    input wire logic        read_strobe_n,
    input wire logic [7:0]  data_oe,
    input wire logic        ready_out,
    input wire logic        ready_oe,
    input wire logic        remote_master_select_n,
    input wire logic        local_timing_setting_select,
    input wire logic [30:0] peer_setup,
    input wire logic        peer_setup_valid,
    input wire logic        peer_is_master,
    input wire logic        setup_to_peer_valid,
    input wire logic [30:0] effective_setup,
    input wire logic        data_path_enable,
    input wire logic        remote_controlled
);
    wire mux_m = host_port_mode_select == 3'h2;
    wire stb_m = host_port_mode_select == 3'h4;
    wire ser_m = host_port_mode_select == 3'h5;
    wire off_m = host_port_mode_select == 3'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rdy_low; $fell(ready_out) && mux_m |-> !ready_out [*2] ##[1:4] ready_out; endproperty
    a_rdy_low: assert property (p_rdy_low) else $error("ready low time wrong");
    property p_rdy_on; $fell(chip_select_n) && (mux_m || stb_m) |-> ##[3:8] ready_oe; endproperty
    a_rdy_on: assert property (p_rdy_on) else $error("ready not driven after select");
    property p_rdy_off; $rose(chip_select_n) && mux_m |-> ##[3:8] !ready_oe; endproperty
    a_rdy_off: assert property (p_rdy_off) else $error("ready not floated");
    property p_rd_drv; $fell(read_strobe_n) && !chip_select_n && mux_m |-> ##[3:8] data_oe == 8'hFF; endproperty
    a_rd_drv: assert property (p_rd_drv) else $error("read data not driven");
    property p_rd_flt; $rose(read_strobe_n) && mux_m |-> ##[3:8] data_oe == 8'h00; endproperty
    a_rd_flt: assert property (p_rd_flt) else $error("read data not floated");
    property p_ack; $rose(ready_oe) && stb_m |-> ready_out ##2 !ready_out; endproperty
    a_ack: assert property (p_ack) else $error("acknowledge timing wrong");
    property p_ser_oe; ser_m [*6] |-> data_oe[7:1] == 7'h00; endproperty
    a_ser_oe: assert property (p_ser_oe) else $error("serial drives extra bits");
    property p_off; off_m [*8] |-> data_oe == 8'h00 && !ready_oe; endproperty
    a_off: assert property (p_off) else $error("bus driven while port off");
    property p_master; !remote_master_select_n [*8] |-> setup_to_peer_valid; endproperty
    a_master: assert property (p_master) else $error("controller not sending setup");
    property p_both;
        (!remote_master_select_n && peer_is_master && peer_setup_valid) [*8] |-> !data_path_enable && !remote_controlled;
    endproperty
    a_both: assert property (p_both) else $error("two controllers left data on");
    property p_remote;
        (remote_controlled && !local_timing_setting_select && $stable(peer_setup)) [*3] |-> effective_setup == peer_setup;
    endproperty
    a_remote: assert property (p_remote) else $error("peer setup not applied");
    c_mux: cover property ($fell(ready_out) && mux_m);
    c_stb: cover property ($rose(ready_oe) && stb_m);
    c_rem: cover property (remote_controlled);
endmodule // hpr_port_chk
bind hpr_host_port hpr_port_chk u_hpr_port_chk (.clk, .arst_n, .host_port_mode_select, .chip_select_n,
    .read_strobe_n, .data_oe, .ready_out, .ready_oe, .remote_master_select_n, .local_timing_setting_select,
    .peer_setup, .peer_setup_valid, .peer_is_master, .setup_to_peer_valid, .effective_setup,
    .data_path_enable, .remote_controlled);

// ### tb/hpr_tb.sv
// bench: register traffic in each port mode, then remote setup
// assumes the host model drives all bus pins
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [2:0]  host_port_mode_select = 3'h0;
    logic        remote_master_select_n = 1'b1;
    logic        local_timing_setting_select = 1'b0;
    logic        peer_setup_valid = 1'b0;
    logic        peer_is_master = 1'b0;
    logic [30:0] local_pin_setup = 31'h1234_5678;
    logic [30:0] peer_setup = 31'h7ABC_DEF0;
    wire         chip_select_n, write_strobe_or_direction, read_strobe_n, latch_strobe;
    wire         ready_out, ready_oe, setup_to_peer_valid, data_path_enable, remote_controlled;
    wire  [4:0]  index_in;
    wire  [7:0]  data_in, data_out, data_oe;
    wire  [30:0] setup_to_peer, effective_setup;
    logic [7:0]  q;
    logic [4:0]  addr [4] = '{5'h00, 5'h01, 5'h02, 5'h03};
    logic [7:0]  val  [4] = '{8'hA5, 8'h3C, 8'h5B, 8'h7E};
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          i;
    hpr_host_port u_hpr_host_port (.clk, .arst_n, .host_port_mode_select, .chip_select_n,
        .write_strobe_or_direction, .read_strobe_n, .latch_strobe, .index_in, .data_in, .data_out, .data_oe,
        .ready_out, .ready_oe, .remote_master_select_n, .local_timing_setting_select, .local_pin_setup,
        .peer_setup, .peer_setup_valid, .peer_is_master, .setup_to_peer, .setup_to_peer_valid,
        .effective_setup, .data_path_enable, .remote_controlled);
    hpr_host_model u_hpr_host_model (.clk, .data_out, .data_oe, .ready_out, .ready_oe, .chip_select_n,
        .write_strobe_or_direction, .read_strobe_n, .latch_strobe, .index_in, .data_in);
    always #12.5 clk = ~clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        wt(6);
        arst_n <= 1'b1;
        host_port_mode_select <= 3'h2;
        wt(12);
        for (i = 0; i < 4; i++) u_hpr_host_model.mux_acc(1'b0, addr[i], val[i], q);
        for (i = 0; i < 4; i++) begin
            u_hpr_host_model.mux_acc(1'b1, addr[i], 8'h00, q);
            chk(32'(q), 32'(val[i]));
        end
        chk(32'(effective_setup), 32'h6F5B_3CA5);
        u_hpr_host_model.mux_acc(1'b0, 5'h1F, 8'hFF, q);
        u_hpr_host_model.mux_acc(1'b1, 5'h1F, 8'h00, q);
        chk(32'(q), 32'h0000_0002);
        u_hpr_host_model.mux_acc(1'b1, 5'h00, 8'h00, q);
        chk(32'(q), 32'h0000_00A5);
        host_port_mode_select <= 3'h4;
        wt(12);
        u_hpr_host_model.stb_acc(1'b0, 5'h00, 8'h96, q);
        u_hpr_host_model.stb_acc(1'b1, 5'h00, 8'h00, q);
        chk(32'(q), 32'h0000_0096);
        u_hpr_host_model.stb_acc(1'b1, 5'h01, 8'h00, q);
        chk(32'(q), 32'h0000_003C);
        host_port_mode_select <= 3'h5;
        wt(12);
        u_hpr_host_model.ser_acc(1'b0, 5'h02, 8'h24, 1'b0, q);
        chk(32'(effective_setup[23:16]), 32'h0000_0024);
        u_hpr_host_model.ser_acc(1'b1, 5'h02, 8'h00, 1'b0, q);
        chk(32'(q), 32'h0000_0024);
        u_hpr_host_model.ser_acc(1'b1, 5'h01, 8'h00, 1'b1, q);
        chk(32'(q), 32'h0000_003C);
        host_port_mode_select <= 3'h0;
        wt(12);
        chk(32'(effective_setup), 32'(local_pin_setup));
        remote_master_select_n <= 1'b0;
        wt(12);
        chk(32'(setup_to_peer_valid), 32'h0000_0001);
        chk(32'(setup_to_peer), 32'(local_pin_setup));
        peer_is_master <= 1'b1;
        peer_setup_valid <= 1'b1;
        wt(12);
        chk(32'(data_path_enable), 32'h0000_0000);
        chk(32'(remote_controlled), 32'h0000_0000);
        remote_master_select_n <= 1'b1;
        wt(12);
        chk(32'(remote_controlled), 32'h0000_0001);
        chk(32'(effective_setup), 32'(peer_setup));
        local_timing_setting_select <= 1'b1;
        wt(12);
        chk(32'(effective_setup), 32'((peer_setup & ~31'h0F00_0000) | (local_pin_setup & 31'h0F00_0000)));
        chk(32'(data_path_enable), 32'h0000_0001);
        close_out();
    end
endmodule // testbench
